// ---- core/i2c_port_defs.svh ----
`ifndef I2C_PORT_DEFS_SVH
`define I2C_PORT_DEFS_SVH

// Register offsets (7-bit pointer space)
`define POWER_CTL_OFFSET 7'h06
`define INT_MASK_OFFSET 7'h35
`define INT_STATUS_OFFSET 7'h36

// Field positions in the power control register
`define ULP_BIT 7
`define LP_BIT 6

// Reset values
`define REG_RESET_VALUE 8'h00
`define POWER_CTL_RESET 8'h00
`define STATUS_RESET 8'h00

// Fixed upper five target address bits
`define TARGET_ADDR_HIGH 5'h12

// Synchroniser idle value: scl, sda high, straps low
`define PIN_IDLE 4'hc

// Cycles after reset release before the straps are caught
`define STRAP_SETTLE 2'h3

// Bit count that marks a whole byte on the wire
`define BYTE_BITS 4'h8

`endif

// ---- core/i2c_port_pkg.sv ----
package i2c_port_pkg;

  // Serial port sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_MAP,
    ST_WRITE,
    ST_READ,
    ST_MACK,
    ST_ACK,
    ST_IGNORE
  } stateType_type;

  // Pins that cross into the mclk domain together
  typedef struct packed {
    logic scl;
    logic sda;
    logic strap1;
    logic strap0;
  } pinsType_type;

endpackage

// ---- core/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for a group of asynchronous pins
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] IDLE = '0
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // Reset to the bus idle level so no false start is seen
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      meta <= IDLE;
      q <= IDLE;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

`default_nettype wire

// ---- core/i2c_register_control_port.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "i2c_port_defs.svh"

// Functional notes
// RQ1: SDA falling while SCL high starts
// RQ2: SDA rising while SCL high stops
// RQ3: SDA changes only while SCL low
// RQ4: First byte: address plus read bit
// RQ5: Answer only to strapped 1001 0xx address
// RQ6: Straps caught after reset release
// RQ7: Unstrapped pins give select bits zero
// RQ8: Pointer byte low seven bits load pointer
// RQ9: Pointer byte MSB enables auto-increment
// RQ10: Device acks received bytes; controller acks reads
// RQ11: Writes go to pointer plus increments
// RQ12: Reads use persisting pointer plus increments
// RQ13: Pointer-only write sets pointer, writes nothing
// RQ14: Port runs asynchronous to audio clocks
// RQ15: Controller reads mask, status only singly
// RQ16: Reading status clears it
// RQ17: Power-down bits keep port alive
// RQ18: Reset powers down, restores defaults
// RQ19: No ack for a foreign address
module i2c_register_control_port
  import i2c_port_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrStrapBit0,
  input wire logic addrStrapBit1,
  input wire logic [7:0] statusEvent,
  output logic ultralowPowerDown,
  output logic blocksPowerDown,
  output logic interruptOut
);

  // Synchronised pins
  pinsType_type pinsRaw;
  pinsType_type pins;
  // Previous synchronised SCL and SDA, for edges
  logic sclQ;
  logic sdaQ;
  // Decoded bus events
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  // Sequencer
  stateType_type state;
  stateType_type ackNext;
  logic [3:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] txByte;
  // Register pointer and auto-increment flag
  logic [6:0] pointer;
  logic autoIncrementFlag;
  // Own address and strap capture
  logic [6:0] ownAddr;
  logic [1:0] strapWait;
  logic strapTaken;
  // Register storage
  logic [7:0] regs [0:127];
  logic [7:0] intStatus;
  // Strobes
  logic byteDone;
  logic wrStrobe;
  logic loadRead;
  logic [7:0] readByte;

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;

  // Pins arrive from the controller's SCL domain
  assign pinsRaw = '{scl: sclIn, sda: sdaIn, strap1: addrStrapBit1, strap0: addrStrapBit0};

  // RQ14: everything is sampled by mclk, no audio clock involved
  pin_sync #(
    .WIDTH(4),
    .IDLE(`PIN_IDLE)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d(pinsRaw),
    .q(pins)
  );

  // Delayed copy for edge finding
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      sclQ <= 1'b1;
      sdaQ <= 1'b1;
    end
    else
    begin
      sclQ <= pins.scl;
      sdaQ <= pins.sda;
    end
  end

  // Edge and condition decode
  always_comb
  begin
    sclRise = pins.scl && !sclQ;
    sclFall = !pins.scl && sclQ;
    startSeen = pins.scl && sclQ && sdaQ && !pins.sda; // RQ1
    stopSeen = pins.scl && sclQ && !sdaQ && pins.sda; // RQ2
  end

  // Byte boundaries and register strobes
  always_comb
  begin
    byteDone = sclFall && (bitCnt == `BYTE_BITS);
    wrStrobe = (state == ST_WRITE) && byteDone;
    loadRead = (state == ST_ACK) && sclFall && (ackNext == ST_READ);
    // RQ12: status has its own latch, the rest come from storage
    readByte = (pointer == `INT_STATUS_OFFSET) ? intStatus : regs[pointer];
  end

  // Strap capture a few cycles after release, once the synchroniser has settled
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      strapWait <= 2'h0;
      strapTaken <= 1'b0;
      ownAddr <= {`TARGET_ADDR_HIGH, 2'b00}; // RQ7
    end
    else if (!strapTaken)
    begin
      if (strapWait == `STRAP_SETTLE)
      begin
        ownAddr <= {`TARGET_ADDR_HIGH, pins.strap1, pins.strap0}; // RQ6
        strapTaken <= 1'b1;
      end
      else
      begin
        strapWait <= strapWait + 2'h1;
      end
    end
  end

  // Serial sequencer; all SDA drive changes happen on a falling SCL
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      state <= ST_IDLE;
      ackNext <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftIn <= 8'h00;
      txByte <= 8'h00;
      sdaOe <= 1'b0;
      pointer <= 7'h00;
      autoIncrementFlag <= 1'b0;
    end
    else if (startSeen)
    begin
      // Also a repeated start
      state <= ST_ADDR; // RQ1
      bitCnt <= 4'h0;
      sdaOe <= 1'b0;
    end
    else if (stopSeen)
    begin
      // Pointer survives the stop
      state <= ST_IDLE; // RQ2 RQ13
      sdaOe <= 1'b0;
    end
    else
    begin
      unique case (state)
        ST_IDLE, ST_IGNORE:
        begin
          // Wait for a start; line stays released
          sdaOe <= 1'b0;
        end
        ST_ADDR, ST_MAP, ST_WRITE:
        begin
          if (sclRise && bitCnt != `BYTE_BITS)
          begin
            // Receive on the rising edge, MSB first
            shiftIn <= {shiftIn[6:0], pins.sda};
            bitCnt <= bitCnt + 4'h1;
          end
          else if (byteDone)
          begin
            bitCnt <= 4'h0;
            if (state == ST_ADDR)
            begin
              if (shiftIn[7:1] == ownAddr) // RQ4 RQ5
              begin
                sdaOe <= 1'b1; // RQ10 RQ3
                state <= ST_ACK;
                ackNext <= shiftIn[0] ? ST_READ : ST_MAP;
              end
              else
              begin
                state <= ST_IGNORE; // RQ19
              end
            end
            else if (state == ST_MAP)
            begin
              pointer <= shiftIn[6:0]; // RQ8
              autoIncrementFlag <= shiftIn[7]; // RQ9
              sdaOe <= 1'b1; // RQ10
              state <= ST_ACK;
              ackNext <= ST_WRITE;
            end
            else
            begin
              // Data byte stored by the register process
              if (autoIncrementFlag)
              begin
                pointer <= pointer + 7'h01; // RQ9 RQ11
              end
              sdaOe <= 1'b1; // RQ10
              state <= ST_ACK;
              ackNext <= ST_WRITE;
            end
          end
        end
        ST_ACK:
        begin
          if (sclFall)
          begin
            state <= ackNext;
            bitCnt <= 4'h0;
            if (ackNext == ST_READ)
            begin
              // First bit goes out in the same low phase
              txByte <= readByte; // RQ12
              sdaOe <= !readByte[7]; // RQ3
              if (autoIncrementFlag)
              begin
                pointer <= pointer + 7'h01; // RQ12
              end
            end
            else
            begin
              sdaOe <= 1'b0;
            end
          end
        end
        ST_READ:
        begin
          if (sclRise)
          begin
            bitCnt <= bitCnt + 4'h1;
          end
          else if (byteDone)
          begin
            // Release for the controller's acknowledge
            sdaOe <= 1'b0;
            state <= ST_MACK;
          end
          else if (sclFall)
          begin
            sdaOe <= !txByte[3'(4'h7 - bitCnt)]; // RQ3
          end
        end
        ST_MACK:
        begin
          if (sclRise)
          begin
            // Low means the controller wants more
            state <= pins.sda ? ST_IGNORE : ST_ACK; // RQ10
            ackNext <= ST_READ;
          end
        end
      endcase
    end
  end

  // Register storage; every pointer except status is written here
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      // RQ18: every register back to its default
      for (int i = 0; i < 128; i++)
      begin
        regs[i] <= `REG_RESET_VALUE;
      end
      regs[`POWER_CTL_OFFSET] <= `POWER_CTL_RESET;
    end
    else if (wrStrobe && pointer != `INT_STATUS_OFFSET)
    begin
      regs[pointer] <= shiftIn; // RQ11
    end
  end

  // Sticky status; a new event wins over the clear by read
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      intStatus <= `STATUS_RESET;
    end
    else if (loadRead && pointer == `INT_STATUS_OFFSET)
    begin
      intStatus <= statusEvent; // RQ16
    end
    else
    begin
      intStatus <= intStatus | statusEvent;
    end
  end

  // Power and interrupt outputs; the port itself is never gated
  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      blocksPowerDown <= 1'b1; // RQ18
      ultralowPowerDown <= 1'b1;
      interruptOut <= 1'b0;
    end
    else
    begin
      blocksPowerDown <= regs[`POWER_CTL_OFFSET][`ULP_BIT] || regs[`POWER_CTL_OFFSET][`LP_BIT]; // RQ17
      ultralowPowerDown <= regs[`POWER_CTL_OFFSET][`ULP_BIT];
      // Mask bit set lets the event through
      interruptOut <= |(intStatus & regs[`INT_MASK_OFFSET]);
    end
  end

  chk_start_enters_addr: // RQ1
  assert property (@(posedge mclk) disable iff (!rst_b)
    startSeen |=> (state == ST_ADDR) && (bitCnt == 4'h0) && !sdaOe)
  else $error("start did not restart the address phase");

  chk_stop_releases: // RQ2
  assert property (@(posedge mclk) disable iff (!rst_b)
    (stopSeen && !startSeen) |=> (state == ST_IDLE) && !sdaOe)
  else $error("stop did not end the transaction");

  chk_drive_scl_low: // RQ3
  assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(sdaOe) |-> !$past(pins.scl))
  else $error("data line pulled while clock high");

  chk_foreign_addr: // RQ19
  assert property (@(posedge mclk) disable iff (!rst_b)
    (state == ST_ADDR && byteDone && !startSeen && !stopSeen && shiftIn[7:1] != ownAddr)
    |=> (state == ST_IGNORE) ##1 !sdaOe)
  else $error("foreign address was answered");

  chk_strap_caught: // RQ6
  assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(strapTaken) |-> ownAddr == {`TARGET_ADDR_HIGH, $past(pins.strap1), $past(pins.strap0)})
  else $error("strap levels not taken as address");

  chk_map_load: // RQ8
  assert property (@(posedge mclk) disable iff (!rst_b)
    (state == ST_MAP && byteDone && !startSeen && !stopSeen)
    |=> ({autoIncrementFlag, pointer} == $past(shiftIn)) && sdaOe)
  else $error("pointer byte not loaded");

  chk_write_step: // RQ11
  assert property (@(posedge mclk) disable iff (!rst_b)
    wrStrobe && !startSeen && !stopSeen
    |=> (pointer == ($past(autoIncrementFlag) ? $past(pointer) + 7'h01 : $past(pointer)))
        && (state == ST_ACK))
  else $error("write pointer step wrong");

  chk_data_ack: // RQ10
  assert property (@(posedge mclk) disable iff (!rst_b)
    (state == ST_WRITE && byteDone && !startSeen && !stopSeen) |=> sdaOe [*1] ##1 (state == ST_ACK))
  else $error("data byte not acknowledged");

  chk_status_clear: // RQ16
  assert property (@(posedge mclk) disable iff (!rst_b)
    (loadRead && !startSeen && !stopSeen && pointer == `INT_STATUS_OFFSET && statusEvent == 8'h00)
    |=> intStatus == 8'h00)
  else $error("status not cleared by read");

  chk_power_down: // RQ17
  assert property (@(posedge mclk) disable iff (!rst_b)
    (wrStrobe && pointer == `POWER_CTL_OFFSET && shiftIn[`LP_BIT])
    |=> ##1 blocksPowerDown && (state == ST_ACK || state == ST_IDLE || state == ST_ADDR))
  else $error("power down not applied");

endmodule

`default_nettype wire

// ---- testbench/i2c_controller_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// Behavioural bus controller; SCL idles high between frames
module i2c_controller_model (
  input wire logic mclk,
  input wire logic sdaBus,
  output logic scl,
  output logic sdaDrv
);
  // Both lines released at time zero
  initial
  begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  // Fixed spacing, all moves on mclk falls
  task automatic hold(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // One 160 ns pulse: data moves mid low, sampled mid high
  task automatic bitx(input logic v, output logic s);
    hold(4);
    sdaDrv = v;
    hold(4);
    scl = 1'b1;
    hold(4);
    s = sdaBus;
    hold(4);
    scl = 1'b0;
  endtask

  // Data falls while clock high; from a low clock a full low phase comes first
  task automatic go_start();
    if (scl == 1'b0)
    begin
      hold(4);
      sdaDrv = 1'b1;
      hold(4);
    end
    sdaDrv = 1'b1;
    scl = 1'b1;
    hold(8);
    sdaDrv = 1'b0;
    hold(8);
    scl = 1'b0;
  endtask

  // Data rises while clock high, then the clock stands still
  task automatic go_stop();
    hold(4);
    sdaDrv = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sdaDrv = 1'b1;
    hold(8);
  endtask

  // MSB first, then the target's acknowledge slot
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], s);
    bitx(1'b1, s);
    ack = !s;
  endtask

  // Released line while the target sends; last byte is not acked
  task automatic rbyte(output logic [7:0] b, input logic last);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, b[i]);
    bitx(last, s);
  endtask
endmodule

`default_nettype wire

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  typedef logic [7:0] byteQ_type[$];
  logic mclk = 1'b0;
  logic rst_b;
  logic addrStrapBit0;
  logic addrStrapBit1;
  logic [7:0] statusEvent;
  logic [6:0] dev; // Expected own address
  wire logic sdaOut;
  wire logic sdaOe;
  wire logic ulp;
  wire logic bpd;
  wire logic intOut;
  wire logic scl;
  wire logic sdaDrv;
  wire logic sdaBus;
  int err_count = 0;
  int cmp_count = 0;

  // Open drain with pull-up: low if either party pulls
  assign sdaBus = sdaDrv & (~sdaOe | sdaOut);

  always #5 mclk = ~mclk;

  i2c_register_control_port i2c_register_control_port_i (
    .mclk(mclk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sdaBus),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapBit0(addrStrapBit0),
    .addrStrapBit1(addrStrapBit1), .statusEvent(statusEvent),
    .ultralowPowerDown(ulp), .blocksPowerDown(bpd), .interruptOut(intOut)
  );

  i2c_controller_model i2c_controller_model_i (
    .mclk(mclk), .sdaBus(sdaBus), .scl(scl), .sdaDrv(sdaDrv)
  );

  // Byte results
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // Flag results
  task automatic chk1(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %b seen %b", n, e, g);
      err_count++;
    end
  endtask

  // Single place where the run ends
  task automatic close_out();
    $display("Compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Reset with new straps; straps stay put afterwards
  task automatic do_reset(input logic s1, input logic s0);
    @(negedge mclk);
    rst_b = 1'b0;
    addrStrapBit1 = s1;
    addrStrapBit0 = s0;
    dev = 7'h48 | {5'h00, s1, s0};
    wait_n(16);
    chk1("ulp in reset", 1'b1, ulp);
    chk1("blocks in reset", 1'b1, bpd);
    rst_b = 1'b1;
    wait_n(8);
  endtask

  // Send one byte and judge the acknowledge
  task automatic put(input logic [7:0] b, input logic exp);
    logic a;
    i2c_controller_model_i.wbyte(b, a);
    chk1("ack", exp, a);
  endtask

  task automatic wr(input logic [7:0] map, input byteQ_type d);
    i2c_controller_model_i.go_start();
    put({dev, 1'b0}, 1'b1);
    put(map, 1'b1);
    foreach (d[i])
      put(d[i], 1'b1);
    i2c_controller_model_i.go_stop();
  endtask

  // Optional pointer preamble, then a read of all expected bytes
  task automatic rd(input logic setMap, input logic [7:0] map, input byteQ_type e);
    logic [7:0] g;
    if (setMap)
    begin
      i2c_controller_model_i.go_start();
      put({dev, 1'b0}, 1'b1);
      put(map, 1'b1);
      i2c_controller_model_i.go_stop();
    end
    i2c_controller_model_i.go_start();
    put({dev, 1'b1}, 1'b1);
    foreach (e[i])
    begin
      i2c_controller_model_i.rbyte(g, i == e.size() - 1);
      chk8("read", e[i], g);
    end
    i2c_controller_model_i.go_stop();
  endtask

  // Foreign address is left unanswered
  task automatic t_addr();
    i2c_controller_model_i.go_start();
    put(8'h94, 1'b0);
    i2c_controller_model_i.go_stop();
    $display("addr test done");
  endtask

  // Incrementing and fixed writes, pointer kept between frames
  task automatic t_burst();
    wr(8'h90, '{8'ha1, 8'hb2, 8'hc3});
    rd(1'b1, 8'h90, '{8'ha1, 8'hb2, 8'hc3});
    rd(1'b1, 8'h90, '{8'ha1});
    rd(1'b0, 8'h00, '{8'hb2});
    wr(8'h20, '{8'h11, 8'h22});
    rd(1'b1, 8'ha0, '{8'h22, 8'h00});
    $display("burst test done");
  endtask

  // Repeated start after the pointer byte turns the frame into a read
  task automatic t_rstart();
    logic [7:0] g;
    i2c_controller_model_i.go_start();
    put({dev, 1'b0}, 1'b1);
    put(8'h12, 1'b1);
    i2c_controller_model_i.go_start();
    put({dev, 1'b1}, 1'b1);
    i2c_controller_model_i.rbyte(g, 1'b1);
    chk8("rstart read", 8'hc3, g);
    i2c_controller_model_i.go_stop();
    $display("rstart test done");
  endtask

  // Power bits drive the outputs, port keeps answering
  task automatic t_power();
    wr(8'h06, '{8'hc0});
    chk1("ulp", 1'b1, ulp);
    chk1("blocks", 1'b1, bpd);
    rd(1'b1, 8'h06, '{8'hc0});
    wr(8'h06, '{8'h40});
    chk1("ulp", 1'b0, ulp);
    chk1("blocks", 1'b1, bpd);
    wr(8'h06, '{8'h00});
    chk1("blocks", 1'b0, bpd);
    $display("power test done");
  endtask

  // Sticky status, masked interrupt, cleared by a single read
  task automatic t_status();
    wr(8'h35, '{8'h01});
    statusEvent = 8'h02;
    wait_n(1);
    statusEvent = 8'h00;
    wait_n(4);
    chk1("int masked", 1'b0, intOut);
    statusEvent = 8'h01;
    wait_n(1);
    statusEvent = 8'h00;
    wait_n(4);
    chk1("int", 1'b1, intOut);
    rd(1'b1, 8'h36, '{8'h03});
    chk1("int cleared", 1'b0, intOut);
    rd(1'b1, 8'h36, '{8'h00});
    $display("status test done");
  endtask

  // Second reset: new straps taken, registers back to defaults
  task automatic t_reset();
    do_reset(1'b1, 1'b1);
    i2c_controller_model_i.go_start();
    put(8'h90, 1'b0);
    i2c_controller_model_i.go_stop();
    rd(1'b1, 8'h90, '{8'h00});
    $display("reset test done");
  endtask

  // Guard against a hung bus
  initial
  begin
    repeat (100000) @(posedge mclk);
    $display("[FAIL] watchdog expected done seen hang");
    err_count++;
    close_out();
  end

  // Main sequence; unstrapped pins read as pulled low
  initial
  begin
    rst_b = 1'b0;
    addrStrapBit0 = 1'b0;
    addrStrapBit1 = 1'b0;
    statusEvent = 8'h00;
    dev = 7'h48;
    do_reset(1'b0, 1'b0);
    t_addr();
    t_burst();
    t_rstart();
    t_power();
    t_status();
    t_reset();
    close_out();
  end
endmodule

`default_nettype wire
